// [core/mihc_flag_group.sv]
`timescale 1ns/1ps
module mihc_flag_group #(
  parameter int W = 4
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  mihc_grp_if.grp   bus
);
  import mihc_pkg::*;

  localparam logic [3:0] USED = ~(4'hF << W);

  logic [3:0] flags_ff;
  logic [3:0] mask_ff;
  logic [3:0] nxt_flags;
  logic [3:0] nxt_mask;

  // Write-one clear, event set wins over clear
  assign nxt_flags = ((bus.wr_flag ? (flags_ff & ~bus.wdata) : flags_ff) | bus.set) & USED;
  assign nxt_mask  = (bus.wr_mask ? bus.wdata : mask_ff) & USED;

  // Flag and mask storage
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flags_ff <= FLAG_RST;
      mask_ff  <= MASK_RST;
    end else begin
      flags_ff <= nxt_flags;
      mask_ff  <= nxt_mask;
    end
  end

  // Outputs toward the controller
  assign bus.flags = flags_ff;
  assign bus.mask  = mask_ff;
  assign bus.req   = |(flags_ff & mask_ff);

  property p_flag_set;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      |(bus.set & USED) |=> ((flags_ff & $past(bus.set & USED)) == $past(bus.set & USED));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event did not set flag");

  property p_flag_clr;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (bus.wr_flag && bus.set == 4'h0) |=> flags_ff == ($past(flags_ff) & ~$past(bus.wdata));
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("write one did not clear");
endmodule

// [core/mihc_top.sv]
`timescale 1ns/1ps
module mihc_top (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_rstn,
  // Avalon-MM slave
  input  wire logic [17:0]                 i_avs_address,
  input  wire logic                        i_avs_read,
  input  wire logic                        i_avs_write,
  input  wire logic [31:0]                 i_avs_writedata,
  input  wire logic [3:0]                  i_avs_byteenable,
  output logic      [31:0]                 o_avs_readdata,
  output logic                             o_avs_waitrequest,
  // Peripheral events
  input  wire logic [1:0]                  i_ptm_match,
  input  wire logic [2:0]                  i_ptm_underflow,
  input  wire logic [3:0]                  i_key_group0,
  input  wire logic [3:0]                  i_key_group1,
  input  wire logic [3:0]                  i_tap_levels,
  input  wire logic                        i_rf_ref_done,
  input  wire logic                        i_rf_tbc_ovf,
  input  wire logic                        i_rf_sens_done,
  input  wire logic                        i_rf_mc_ovf,
  input  wire logic                        i_wdt_req,
  // CPU core side
  input  wire logic                        i_cpu_insn_end,
  input  wire logic                        i_cpu_halt,
  input  wire logic                        i_cpu_ei,
  input  wire logic                        i_cpu_di,
  input  wire logic                        i_cpu_return_from_interrupt,
  input  wire logic                        i_sp1_wr,
  input  wire logic                        i_sp2_wr,
  output logic                             o_cpu_halted,
  output logic                             o_interrupts_on_state,
  output logic                             o_save_flags,
  output logic                             o_push_pc,
  output logic                             o_load_pc,
  output logic      [mihc_pkg::VEC_W-1:0]  o_vector,
  output logic                             o_irq_pending
);
  import mihc_pkg::*;

  mihc_grp_if g_if [NGRP] ();

  // ---- Bus slave state ----
  logic        ack_ff;
  logic [31:0] rd_ff;
  logic [3:0]  rd_mux;
  wire         bus_req = i_avs_read | i_avs_write;
  wire  [15:0] bus_idx = i_avs_address[17:2];
  wire         wr_go   = i_avs_write & ack_ff & i_avs_byteenable[0];
  wire         rd_cap  = i_avs_read & ~ack_ff;

  // ---- Event detection state ----
  logic [7:0] key_s1_ff;
  logic [7:0] key_s2_ff;
  logic [7:0] key_prev_ff;
  logic [1:0] key_arm_ff;
  logic [3:0] tap_prev_ff;
  logic       nmi_pend_ff;

  // ---- Interrupt entry state ----
  mihc_state_e state_ff;
  mihc_state_e nxt_state;
  logic        ie_ff;
  logic        nxt_ie;
  logic        saved_ie_ff;
  logic        sp1_ok_ff;
  logic        sp2_ok_ff;
  logic        halted_ff;
  logic [3:0]  vec_low_ff;
  logic [3:0]  nxt_vec_low;

  // One wait cycle, then answer
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req & ~ack_ff;
    end
  end

  assign o_avs_waitrequest = bus_req & ~ack_ff;

  // Read data captured in the wait cycle
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_ff <= 32'h0000_0000;
    end else if (rd_cap) begin
      rd_ff <= {28'h000_0000, rd_mux};
    end
  end

  assign o_avs_readdata = rd_ff;

  // Per-group write strobes and data
  genvar gi;
  generate
    for (gi = 0; gi < NGRP; gi++) begin : g_grp
      assign g_if[gi].wdata   = i_avs_writedata[3:0];
      assign g_if[gi].wr_flag = wr_go & (bus_idx == FLAG_IDX[gi]);
      assign g_if[gi].wr_mask = wr_go & (bus_idx == MASK_IDX[gi]);

      mihc_flag_group #(
        .W (GRP_W[gi])
      ) u_grp (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .bus       (g_if[gi])
      );
    end
  endgenerate

  // Read selection; unmapped reads return zero
  always_comb begin
    rd_mux = 4'h0;
    if (bus_idx == FLAG_IDX[G_PTC]) rd_mux = g_if[G_PTC].flags;
    if (bus_idx == FLAG_IDX[G_PTU]) rd_mux = g_if[G_PTU].flags;
    if (bus_idx == FLAG_IDX[G_K0])  rd_mux = g_if[G_K0].flags;
    if (bus_idx == FLAG_IDX[G_K1])  rd_mux = g_if[G_K1].flags;
    if (bus_idx == FLAG_IDX[G_TAP]) rd_mux = g_if[G_TAP].flags;
    if (bus_idx == FLAG_IDX[G_RF])  rd_mux = g_if[G_RF].flags;
    if (bus_idx == MASK_IDX[G_PTC]) rd_mux = g_if[G_PTC].mask;
    if (bus_idx == MASK_IDX[G_PTU]) rd_mux = g_if[G_PTU].mask;
    if (bus_idx == MASK_IDX[G_K0])  rd_mux = g_if[G_K0].mask;
    if (bus_idx == MASK_IDX[G_K1])  rd_mux = g_if[G_K1].mask;
    if (bus_idx == MASK_IDX[G_TAP]) rd_mux = g_if[G_TAP].mask;
    if (bus_idx == MASK_IDX[G_RF])  rd_mux = g_if[G_RF].mask;
    if (bus_idx == STAT_IDX)        rd_mux = {halted_ff, sp1_ok_ff & sp2_ok_ff,
                                              ie_ff, nmi_pend_ff};
  end

  // Key pins: two-stage sync, then edge history
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      key_s1_ff   <= 8'h00;
      key_s2_ff   <= 8'h00;
      key_prev_ff <= 8'h00;
    end else begin
      key_s1_ff   <= {i_key_group1, i_key_group0};
      key_s2_ff   <= key_s1_ff;
      key_prev_ff <= key_s2_ff;
    end
  end

  // Hide the reset-to-pin-level step
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      key_arm_ff <= 2'h0;
    end else if (key_arm_ff != KEY_ARM) begin
      key_arm_ff <= key_arm_ff + 2'h1;
    end
  end

  // Tap history for falling edges
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tap_prev_ff <= 4'h0;
    end else begin
      tap_prev_ff <= i_tap_levels;
    end
  end

  wire [7:0] key_edge = (key_arm_ff == KEY_ARM) ? (key_s2_ff ^ key_prev_ff) : 8'h00;
  wire [3:0] tap_fall = tap_prev_ff & ~i_tap_levels;

  // Event routing into flag groups
  assign g_if[G_PTC].set = {2'b00, i_ptm_match};
  assign g_if[G_PTU].set = {1'b0, i_ptm_underflow};
  assign g_if[G_K0].set  = {3'b000, |key_edge[3:0]};
  assign g_if[G_K1].set  = {3'b000, |key_edge[7:4]};
  assign g_if[G_TAP].set = tap_fall;
  assign g_if[G_RF].set  = {2'b00, i_rf_ref_done | i_rf_tbc_ovf,
                            i_rf_sens_done | i_rf_mc_ovf};

  // Masked requests per vector
  wire [3:0] tap_act = g_if[G_TAP].flags & g_if[G_TAP].mask;
  wire       rq_rf   = g_if[G_RF].req;
  wire       rq_ptc  = g_if[G_PTC].req;
  wire       rq_ptu  = g_if[G_PTU].req;
  wire       rq_k0   = g_if[G_K0].req;
  wire       rq_k1   = g_if[G_K1].req;
  wire       rq_taph = |tap_act[3:2];
  wire       rq_tapl = |tap_act[1:0];
  wire       mreq    = rq_rf | rq_ptc | rq_ptu | rq_k0 | rq_k1 | rq_taph | rq_tapl;

  // Acceptance conditions
  wire sp_ok   = sp1_ok_ff & sp2_ok_ff;
  wire at_bnd  = i_cpu_insn_end | halted_ff;
  wire nmi_go  = nmi_pend_ff;
  wire mask_go = ie_ff & mreq;
  wire take    = (state_ff == ST_IDLE) & sp_ok & at_bnd & (nmi_go | mask_go);
  wire wake    = sp_ok & (nmi_pend_ff | mreq);

  assign o_irq_pending = sp_ok & (nmi_go | mask_go);

  // Fixed priority, watchdog first
  always_comb begin
    if (nmi_go)        nxt_vec_low = VEC_WDT;
    else if (rq_rf)    nxt_vec_low = VEC_RF;
    else if (rq_ptc)   nxt_vec_low = VEC_PTC;
    else if (rq_ptu)   nxt_vec_low = VEC_PTU;
    else if (rq_k0)    nxt_vec_low = VEC_K0;
    else if (rq_k1)    nxt_vec_low = VEC_K1;
    else if (rq_taph)  nxt_vec_low = VEC_TAPH;
    else               nxt_vec_low = VEC_TAPL;
  end

  // Watchdog request latch, set wins over clear
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      nmi_pend_ff <= 1'b0;
    end else begin
      nmi_pend_ff <= i_wdt_req | (nmi_pend_ff & ~(take & nmi_go));
    end
  end

  // Stack pointer pair interlock
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sp1_ok_ff <= 1'b0;
      sp2_ok_ff <= 1'b0;
    end else begin
      if (i_sp1_wr & i_sp2_wr) begin
        sp1_ok_ff <= 1'b1;
        sp2_ok_ff <= 1'b1;
      end else if (i_sp1_wr) begin
        sp1_ok_ff <= 1'b1;
        sp2_ok_ff <= sp2_ok_ff & ~sp1_ok_ff;
      end else if (i_sp2_wr) begin
        sp2_ok_ff <= 1'b1;
        sp1_ok_ff <= sp1_ok_ff & ~sp2_ok_ff;
      end
    end
  end

  // Entry sequence
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_state = ST_SAVE;
        end
      end
      ST_SAVE: nxt_state = ST_PUSH;
      ST_PUSH: nxt_state = ST_LOAD;
      ST_LOAD: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Vector latched at acceptance
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      vec_low_ff <= VEC_WDT;
    end else if (take) begin
      vec_low_ff <= nxt_vec_low;
    end
  end

  // Enable flag: entry clear beats return and enable
  always_comb begin
    nxt_ie = ie_ff;
    if (i_cpu_ei) nxt_ie = 1'b1;
    if (i_cpu_di) nxt_ie = 1'b0;
    if (i_cpu_return_from_interrupt) nxt_ie = saved_ie_ff;
    if (take) nxt_ie = 1'b0;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ie_ff       <= 1'b0;
      saved_ie_ff <= 1'b0;
    end else begin
      ie_ff <= nxt_ie;
      if (take) begin
        saved_ie_ff <= ie_ff;
      end
    end
  end

  // Halt until any request appears
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      halted_ff <= 1'b0;
    end else if (wake) begin
      halted_ff <= 1'b0;
    end else if (i_cpu_halt) begin
      halted_ff <= 1'b1;
    end
  end

  // CPU side outputs
  assign o_cpu_halted          = halted_ff;
  assign o_interrupts_on_state = ie_ff;
  assign o_save_flags          = (state_ff == ST_SAVE);
  assign o_push_pc             = (state_ff == ST_PUSH);
  assign o_load_pc             = (state_ff == ST_LOAD);
  assign o_vector              = {VEC_BASE, vec_low_ff};

  // Checks
  property p_sp_block;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (state_ff == ST_IDLE && !sp_ok) |=> state_ff == ST_IDLE;
  endproperty
  a_sp_block: assert property (p_sp_block) else $error("entry before pointer pair");

  property p_single_sp;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (sp_ok && i_sp1_wr && !i_sp2_wr) |=> !sp_ok;
  endproperty
  a_single_sp: assert property (p_single_sp) else $error("lone pointer write not blocking");

  property p_mask_gate;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (state_ff == ST_IDLE && !ie_ff && !nmi_pend_ff) |=> state_ff == ST_IDLE;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("maskable taken while gated");

  property p_ie_clear;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      take |=> (!ie_ff && state_ff == ST_SAVE);
  endproperty
  a_ie_clear: assert property (p_ie_clear) else $error("enable flag not cleared");

  property p_nmi_take;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (state_ff == ST_IDLE && nmi_pend_ff && sp_ok && at_bnd)
        |=> (state_ff == ST_SAVE && vec_low_ff == VEC_WDT);
  endproperty
  a_nmi_take: assert property (p_nmi_take) else $error("watchdog not taken first");

  property p_boundary;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      o_save_flags |-> $past(i_cpu_insn_end || halted_ff);
  endproperty
  a_boundary: assert property (p_boundary) else $error("entry inside instruction");

  sequence s_entry;
    o_save_flags ##1 o_push_pc ##1 (o_load_pc && o_vector[15:4] == VEC_BASE);
  endsequence

  property p_order;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      take |=> s_entry;
  endproperty
  a_order: assert property (p_order) else $error("entry steps out of order");

  property p_rf_prio;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (take && !nmi_pend_ff && rq_rf) |=> vec_low_ff == VEC_RF;
  endproperty
  a_rf_prio: assert property (p_rf_prio) else $error("wrong priority vector");

  property p_wake;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (halted_ff && wake) |=> !halted_ff;
  endproperty
  a_wake: assert property (p_wake) else $error("halt not released");

  property p_return_from_interrupt;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (i_cpu_return_from_interrupt && !take) |=> ie_ff == $past(saved_ie_ff);
  endproperty
  a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return did not restore flag");

  // Main scenarios
  c_nmi:   cover property (@(posedge i_sys_clk) disable iff (!i_rstn) take && nmi_go);
  c_mask:  cover property (@(posedge i_sys_clk) disable iff (!i_rstn) take && !nmi_go);
  c_wake:  cover property (@(posedge i_sys_clk) disable iff (!i_rstn) halted_ff && wake);
  c_write: cover property (@(posedge i_sys_clk) disable iff (!i_rstn) wr_go);
endmodule

// [shared/mihc_grp_if.sv]
`timescale 1ns/1ps
interface mihc_grp_if;
  logic [3:0] set;
  logic [3:0] wdata;
  logic       wr_flag;
  logic       wr_mask;
  logic [3:0] flags;
  logic [3:0] mask;
  logic       req;

  modport grp (input set, wdata, wr_flag, wr_mask, output flags, mask, req);
  modport top (output set, wdata, wr_flag, wr_mask, input flags, mask, req);
endinterface

// [shared/mihc_pkg.sv]
// Operation
// - Maskable request needs enable flag and mask
// - Taking any interrupt clears the enable flag
// - Watchdog request ignores enable flag and masks
// - After reset nothing taken until both pointers written
// - One pointer written alone blocks all requests
// - Halt stops CPU; any request restarts it
// - Source event sets flag regardless of mask
// - Interrupt when flag, mask and enable all one
// - Writing one clears flag; zero leaves it
// - Reset clears every factor flag
// - Masks read/write, one enables, reset clears
// - Timer match and underflow flag bit placement
// - Each key group edge sets its flag
// - Clock taps set flags on falling edge
// - Converter completions set reference and sensor flags
// - Counter overflows also set the completion flags
// - Mask sits 10H below its flag, same bit
// - Entry starts only after current instruction ends
// - Save flags, push counter, then load vector
// - Vector table and fixed priority order
// - Request supplies only low four counter bits
package mihc_pkg;

  localparam int NGRP = 6;
  localparam int VEC_W = 16;

  // Group order used for every per-group table below
  localparam int G_PTC = 0;
  localparam int G_PTU = 1;
  localparam int G_K0  = 2;
  localparam int G_K1  = 3;
  localparam int G_TAP = 4;
  localparam int G_RF  = 5;

  // Implemented bits per group
  localparam int GRP_W [NGRP] = '{2, 3, 1, 1, 4, 2};

  // Register indexes; byte address is four times the index
  localparam logic [15:0] MASK_IDX [NGRP] = '{16'hFFE0, 16'hFFE1, 16'hFFE3,
                                               16'hFFE4, 16'hFFE5, 16'hFFE7};
  localparam logic [15:0] FLAG_IDX [NGRP] = '{16'hFFF0, 16'hFFF1, 16'hFFF3,
                                               16'hFFF4, 16'hFFF5, 16'hFFF7};
  localparam logic [15:0] STAT_IDX = 16'hFFD0;

  // Reset values
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [3:0] FLAG_RST = 4'h0;

  // Vector base and low nibbles
  localparam logic [11:0] VEC_BASE = 12'h010;
  localparam logic [3:0]  VEC_WDT  = 4'h0;
  localparam logic [3:0]  VEC_RF   = 4'h2;
  localparam logic [3:0]  VEC_PTC  = 4'h4;
  localparam logic [3:0]  VEC_PTU  = 4'h6;
  localparam logic [3:0]  VEC_K0   = 4'h8;
  localparam logic [3:0]  VEC_K1   = 4'hA;
  localparam logic [3:0]  VEC_TAPH = 4'hC;
  localparam logic [3:0]  VEC_TAPL = 4'hE;

  // Key input settle cycles after reset
  localparam logic [1:0] KEY_ARM = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAVE = 2'b01,
    ST_PUSH = 2'b10,
    ST_LOAD = 2'b11
  } mihc_state_e;

endpackage

// [verification/mihc_cpu_model.sv]
`timescale 1ns/1ps
// CPU core stand-in: instruction ends, control pulses, vector capture
module mihc_cpu_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_halted,
  input  wire logic        i_slow,
  input  wire logic        i_load_pc,
  input  wire logic [15:0] i_vector,
  output logic             o_insn_end,
  output logic [5:0]       o_ctl,
  output logic [15:0]      o_taken_vec,
  output int               o_n_taken
);
  logic [1:0] cnt_ff = 2'h0;

  initial begin
    o_insn_end = 1'b0;
    o_ctl = 6'h00;
    o_taken_vec = 16'h0000;
    o_n_taken = 0;
  end

  // Instruction ends each cycle, or every fourth when slow; none in halt
  always @(posedge i_sys_clk) begin
    cnt_ff <= cnt_ff + 2'h1;
    o_insn_end <= !i_halted && (!i_slow || cnt_ff == 2'h3);
  end

  // Program counter load takes the vector
  always @(posedge i_sys_clk) begin
    if (i_load_pc) begin
      o_taken_vec <= i_vector;
      o_n_taken <= o_n_taken + 1;
    end
  end

  // One-cycle control pulse: halt, on, off, return, first, second pointer
  task automatic send(input logic [5:0] c);
    @(posedge i_sys_clk);
    o_ctl <= c;
    @(posedge i_sys_clk);
    o_ctl <= 6'h00;
  endtask
endmodule

// [verification/mihc_interrupt_and_halt_control_bench.sv]
`timescale 1ns/1ps
module mihc_interrupt_and_halt_control_bench;
  import mihc_pkg::*;
  localparam logic [5:0] C_HALT = 6'h01;
  localparam logic [5:0] C_ON   = 6'h02;
  localparam logic [5:0] C_OFF  = 6'h04;
  localparam logic [5:0] C_RET  = 6'h08;
  localparam logic [5:0] C_SP1  = 6'h10;
  localparam logic [5:0] C_SP2  = 6'h20;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [17:0] adr = 18'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0]  be = 4'hF;
  logic [1:0]  mt = 2'h0;
  logic [2:0]  uf = 3'h0;
  logic [3:0]  k0 = 4'h0;
  logic [3:0]  k1 = 4'h0;
  logic [3:0]  tp = 4'h0;
  logic [3:0]  rf = 4'h0;
  logic        wdt = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] rdata;
  logic        wreq;
  logic        halted;
  logic        ie;
  logic        save;
  logic        push;
  logic        load;
  logic        pend;
  logic [15:0] vec;
  logic        iend;
  logic [5:0]  ctl;
  logic [15:0] tvec;
  int          ntk;
  logic        p_save = 1'b0;
  logic        p_push = 1'b0;
  logic        p_end = 1'b0;
  logic        p_pnd = 1'b0;
  int          n_seen = 0;
  logic [3:0]  d;
  int          n_mismatch = 0;
  int          n_compared = 0;

  mihc_top dut (.i_sys_clk(clk), .i_rstn(rstn), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_ptm_match(mt), .i_ptm_underflow(uf), .i_key_group0(k0),
    .i_key_group1(k1), .i_tap_levels(tp), .i_rf_ref_done(rf[3]), .i_rf_tbc_ovf(rf[2]),
    .i_rf_sens_done(rf[1]), .i_rf_mc_ovf(rf[0]), .i_wdt_req(wdt), .i_cpu_insn_end(iend),
    .i_cpu_halt(ctl[0]), .i_cpu_ei(ctl[1]), .i_cpu_di(ctl[2]), .i_cpu_return_from_interrupt(ctl[3]),
    .i_sp1_wr(ctl[4]), .i_sp2_wr(ctl[5]), .o_cpu_halted(halted), .o_interrupts_on_state(ie),
    .o_save_flags(save), .o_push_pc(push), .o_load_pc(load), .o_vector(vec),
    .o_irq_pending(pend));

  mihc_cpu_model cpu (.i_sys_clk(clk), .i_halted(halted), .i_slow(slow), .i_load_pc(load),
    .i_vector(vec), .o_insn_end(iend), .o_ctl(ctl), .o_taken_vec(tvec), .o_n_taken(ntk));

  // Clock, 8 ns period
  always #4 clk = ~clk;

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      n_mismatch++;
    end
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Entry order and boundary, watched mid-cycle
  always @(negedge clk) begin
    if (p_save) chk("push", push, 1'b1);
    if (p_push) chk("load", load, 1'b1);
    if (save === 1'b1) chk("boundary", p_end, 1'b1);
    if (save === 1'b1) chk("pending", p_pnd, 1'b1);
    p_pnd <= (pend === 1'b1);
    p_save <= (save === 1'b1);
    p_push <= (push === 1'b1);
    p_end <= (iend | halted) === 1'b1;
  end

  // Request held until waitrequest is sampled low at a rising edge
  task automatic av(input logic w, input logic [15:0] idx, input logic [3:0] v);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= {idx, 2'b00};
    wd <= {28'h0, v};
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    d = rdata[3:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rchk(input logic [15:0] idx, input logic [3:0] exp);
    av(1'b0, idx, 4'h0);
    chk("register", {idx[11:0], d}, {idx[11:0], exp});
  endtask

  task automatic src(input logic [1:0] m, input logic [2:0] u, input logic [3:0] r,
                     input logic w);
    @(posedge clk);
    mt <= m;
    uf <= u;
    rf <= r;
    wdt <= w;
    @(posedge clk);
    mt <= 2'h0;
    uf <= 3'h0;
    rf <= 4'h0;
    wdt <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  // Entries are counted against those already judged, so an early one is not missed
  task automatic take(input logic [15:0] v);
    int n;
    n = 0;
    while (ntk == n_seen && n < 200) begin
      @(posedge clk);
      n++;
    end
    n_seen++;
    chk("entries", ntk, n_seen);
    chk("vector", tvec, v);
    chk("on_state", ie, 1'b0);
  endtask

  task automatic none();
    repeat (40) @(posedge clk);
    chk("no_entry", ntk, n_seen);
  endtask

  task automatic t_reset();
    for (int g = 0; g < NGRP; g++) begin
      rchk(MASK_IDX[g], 4'h0);
      rchk(FLAG_IDX[g], 4'h0);
    end
    rchk(STAT_IDX, 4'h0);
  endtask

  task automatic t_masks();
    for (int g = 0; g < NGRP; g++) begin
      av(1'b1, FLAG_IDX[g] - 16'h0010, 4'hF);
      rchk(MASK_IDX[g], 4'((1 << GRP_W[g]) - 1));
    end
    be <= 4'h0;
    av(1'b1, MASK_IDX[G_TAP], 4'h0);
    be <= 4'hF;
    rchk(MASK_IDX[G_TAP], 4'hF);
    av(1'b1, 16'hFFE2, 4'hF);
    rchk(16'hFFE2, 4'h0);
    for (int g = 0; g < NGRP; g++) av(1'b1, MASK_IDX[g], 4'h0);
  endtask

  task automatic t_flags();
    logic [3:0] rf_src [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
    logic [3:0] rf_exp [4] = '{4'h2, 4'h2, 4'h1, 4'h1};
    src(2'h2, 3'h4, 4'h0, 1'b0);
    rchk(16'hFFF0, 4'h2);
    rchk(16'hFFF1, 4'h4);
    src(2'h1, 3'h3, 4'h0, 1'b0);
    rchk(16'hFFF0, 4'h3);
    rchk(16'hFFF1, 4'h7);
    av(1'b1, 16'hFFF0, 4'h1);
    rchk(16'hFFF0, 4'h2);
    av(1'b1, 16'hFFF0, 4'h0);
    rchk(16'hFFF0, 4'h2);
    k0 <= 4'h8;
    src(2'h0, 3'h0, 4'h0, 1'b0);
    rchk(16'hFFF3, 4'h1);
    rchk(16'hFFF4, 4'h0);
    k1 <= 4'h2;
    src(2'h0, 3'h0, 4'h0, 1'b0);
    rchk(16'hFFF4, 4'h1);
    tp <= 4'hF;
    src(2'h0, 3'h0, 4'h0, 1'b0);
    rchk(16'hFFF5, 4'h0);
    tp <= 4'h0;
    src(2'h0, 3'h0, 4'h0, 1'b0);
    rchk(16'hFFF5, 4'hF);
    for (int i = 0; i < 4; i++) begin
      src(2'h0, 3'h0, rf_src[i], 1'b0);
      rchk(16'hFFF7, rf_exp[i]);
      av(1'b1, 16'hFFF7, 4'hF);
    end
    for (int g = 0; g < NGRP; g++) av(1'b1, FLAG_IDX[g], 4'hF);
  endtask

  task automatic t_pointers();
    src(2'h0, 3'h0, 4'h0, 1'b1);
    none();
    cpu.send(C_SP1);
    none();
    cpu.send(C_SP2);
    take(16'h0100);
    cpu.send(C_SP1);
    src(2'h0, 3'h0, 4'h0, 1'b1);
    none();
    cpu.send(C_SP2);
    take(16'h0100);
    rchk(STAT_IDX, 4'h4);
  endtask

  task automatic t_gate();
    src(2'h1, 3'h0, 4'h0, 1'b0);
    cpu.send(C_ON);
    none();
    chk("pending", pend, 1'b0);
    av(1'b1, MASK_IDX[G_PTC], 4'h1);
    take(16'h0104);
    cpu.send(C_RET);
    take(16'h0104);
    av(1'b1, FLAG_IDX[G_PTC], 4'hF);
    cpu.send(C_ON);
    none();
    chk("on_state", ie, 1'b1);
    cpu.send(C_OFF);
  endtask

  task automatic t_priority();
    logic [3:0] vlo [7] = '{4'h2, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC, 4'hE};
    int         grp [7] = '{G_RF, G_PTC, G_PTU, G_K0, G_K1, G_TAP, G_TAP};
    logic [3:0] clr [7] = '{4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hC, 4'h3};
    for (int g = 0; g < NGRP; g++) av(1'b1, MASK_IDX[g], 4'hF);
    tp <= 4'hF;
    k0 <= 4'h0;
    k1 <= 4'h0;
    src(2'h3, 3'h7, 4'hA, 1'b0);
    tp <= 4'h0;
    src(2'h0, 3'h0, 4'h0, 1'b1);
    take(16'h0100);
    for (int i = 0; i < 7; i++) begin
      cpu.send(C_ON);
      take({12'h010, vlo[i]});
      av(1'b1, FLAG_IDX[grp[i]], clr[i]);
    end
    cpu.send(C_ON);
    none();
    cpu.send(C_OFF);
  endtask

  task automatic t_halt();
    cpu.send(C_HALT);
    repeat (4) @(posedge clk);
    chk("halted", halted, 1'b1);
    src(2'h0, 3'h1, 4'h0, 1'b0);
    chk("halted", halted, 1'b0);
    av(1'b1, FLAG_IDX[G_PTU], 4'hF);
    cpu.send(C_HALT);
    src(2'h0, 3'h0, 4'h0, 1'b1);
    chk("halted", halted, 1'b0);
    take(16'h0100);
  endtask

  task automatic t_boundary();
    slow <= 1'b1;
    cpu.send(C_ON);
    src(2'h2, 3'h0, 4'h0, 1'b0);
    take(16'h0104);
    av(1'b1, FLAG_IDX[G_PTC], 4'hF);
    slow <= 1'b0;
  endtask

  // Timeout guard
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_masks();
    t_flags();
    t_pointers();
    t_gate();
    t_priority();
    t_halt();
    t_boundary();
    close_out();
  end
endmodule
